// >>> rtl/dinit_consts.svh
// Timing and encoding constants for the DDR3 init controller
`ifndef DINIT_CONSTS_SVH
`define DINIT_CONSTS_SVH
`define DINIT_CLK_NS          10
`define DINIT_T_RST_PWR_NS    200000
`define DINIT_T_RST_WARM_NS   100
`define DINIT_T_CKE_RST_NS    10
`define DINIT_T_RST_CKE_NS    500000
`define DINIT_T_CKSTAB_NS     10
`define DINIT_CKSTAB_MIN_CYC  5
`define DINIT_TXS_NS          170
`define DINIT_TXPR_MIN_CYC    5
`define DINIT_TMRD_CYC        4
`define DINIT_TMOD_CYC        12
`define DINIT_TDLLK_CYC       512
`define DINIT_TZQINIT_CYC     512
`define DINIT_CYC(ns)         ((((ns) + `DINIT_CLK_NS - 1) / `DINIT_CLK_NS))
`define DINIT_BA_MR0          3'h0
`define DINIT_BA_MR1          3'h1
`define DINIT_BA_MR2          3'h2
`define DINIT_BA_MR3          3'h3
`define DINIT_A_DLL_EN_BIT    0
`define DINIT_A_DLL_RST_BIT   8
`define DINIT_A_ZQ_LONG_BIT   10
`define DINIT_REG_CTRL        8'h00
`define DINIT_REG_STATUS      8'h04
`define DINIT_REG_MR0         8'h08
`define DINIT_REG_MR1         8'h0C
`define DINIT_REG_MR2         8'h10
`define DINIT_REG_MR3         8'h14
`define DINIT_REG_MRS         8'h18
`define DINIT_CTRL_START      0
`define DINIT_CTRL_WARM       1
`define DINIT_CTRL_ODT_HI     2
`define DINIT_ST_DONE         0
`define DINIT_ST_BUSY         1
`define DINIT_ST_MRS_BUSY     2
`endif

// >>> rtl/dinit_pkg.sv
// Types shared by the DDR3 init controller
package dinit_pkg;
    // Command on RAS#/CAS#/WE# with CS#; active-low encodings
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dinit_cmd_t;

    localparam dinit_cmd_t DINIT_NOP  = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
    localparam dinit_cmd_t DINIT_MRS  = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0};
    localparam dinit_cmd_t DINIT_ZQCL = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b0};

    typedef struct packed {
        logic       reset_n;
        logic       cke;
        logic       odt;
        dinit_cmd_t cmd;
        logic [2:0] ba;
        logic [14:0] addr;
    } dinit_pins_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        valid;
    } dinit_ax_t;
endpackage

// >>> rtl/dinit_timer.sv
// Down-counting wait timer; done is a level once the load has run out
module dinit_timer
    import dinit_pkg::*;
#(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } dinit_tmr_st_t;
    dinit_tmr_st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.cnt = value;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = (s_q.cnt == '0) && !load;

    property p_count_down;
        @(posedge clk) disable iff (!rst_n)
        (s_q.cnt != '0 && !load) |=> s_q.cnt == $past(s_q.cnt) - 1'b1;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("timer failed to count down");
endmodule

// >>> rtl/dinit_axil.sv
// AXI4-Lite slave front end: one write and one read at a time
module dinit_axil
    import dinit_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok,
    input  wire logic        wr_ok
);
    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awa;
        logic [31:0] wd;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dinit_ax_st_t;
    dinit_ax_st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (s_awvalid && s_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awa    = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            s_d.w_got = 1'b1;
            s_d.wd    = s_wdata;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = wr_ok ? 2'h0 : 2'h2;
        end
        if (s_q.bvalid && s_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_data;
            s_d.rresp  = rd_ok ? 2'h0 : 2'h2;
        end else if (s_q.rvalid && s_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_bvalid  = s_q.bvalid;
    assign s_bresp   = s_q.bresp;
    assign s_arready = !s_q.rvalid;
    assign s_rvalid  = s_q.rvalid;
    assign s_rdata   = s_q.rdata;
    assign s_rresp   = s_q.rresp;
    assign wr_en     = s_q.aw_got && s_q.w_got;
    assign wr_addr   = s_q.awa;
    assign wr_data   = s_q.wd;
    assign rd_en     = s_arvalid && s_arready;
    assign rd_addr   = s_araddr;

    property p_b_after_w;
        @(posedge clk) disable iff (!rst_n)
        wr_en |=> s_bvalid;
    endproperty
    a_b_after_w: assert property (p_b_after_w) else $error("write response missing");
endmodule

// >>> rtl/dinit_ctrl.sv
// DDR3 power-up / reset initialization and mode register controller
//
// The address map and the AXI4-Lite slave port were decided locally.
`include "dinit_consts.svh"
module dinit_ctrl
    import dinit_pkg::*;
#(
    parameter int T_RST_PWR_CYC = `DINIT_CYC(`DINIT_T_RST_PWR_NS),
    parameter int T_RST_CKE_CYC = `DINIT_CYC(`DINIT_T_RST_CKE_NS),
    parameter int TMRD_CYC      = `DINIT_TMRD_CYC,
    parameter int TMOD_CYC      = `DINIT_TMOD_CYC,
    parameter int TDLLK_CYC     = `DINIT_TDLLK_CYC,
    parameter int TZQINIT_CYC   = `DINIT_TZQINIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic             ck_en,
    output dinit_pkg::dinit_pins_t mem
);
    import dinit_pkg::*;

    localparam int TW        = 20;
    localparam int WARM_CYC  = `DINIT_CYC(`DINIT_T_RST_WARM_NS);
    localparam int CKE_RST   = `DINIT_CYC(`DINIT_T_CKE_RST_NS);
    localparam int CKSTAB    = (`DINIT_CYC(`DINIT_T_CKSTAB_NS) > `DINIT_CKSTAB_MIN_CYC) ?
                               `DINIT_CYC(`DINIT_T_CKSTAB_NS) : `DINIT_CKSTAB_MIN_CYC;
    localparam int TXPR_CYC  = (`DINIT_CYC(`DINIT_TXS_NS) > `DINIT_TXPR_MIN_CYC) ?
                               `DINIT_CYC(`DINIT_TXS_NS) : `DINIT_TXPR_MIN_CYC;
    localparam int TFIN_CYC  = (TDLLK_CYC > TZQINIT_CYC) ? TDLLK_CYC : TZQINIT_CYC;

    typedef enum logic [10:0] {
        ST_IDLE  = 11'h001,
        ST_RST   = 11'h002,
        ST_CKELO = 11'h004,
        ST_RWAIT = 11'h008,
        ST_CKSTB = 11'h010,
        ST_XPR   = 11'h020,
        ST_MRS   = 11'h040,
        ST_GAP   = 11'h080,
        ST_ZQ    = 11'h100,
        ST_FIN   = 11'h200,
        ST_READY = 11'h400
    } dinit_state_t;

    typedef struct packed {
        dinit_state_t st;
        dinit_pins_t  pin;
        logic [1:0]   idx;
        logic         warm;
        logic         odt_hi;
        logic         done;
        logic         rt_mrs;
        logic [2:0]   rt_ba;
        logic [14:0]  rt_a;
        logic [14:0] mr0, mr1, mr2, mr3;
        logic         ck_en;
        logic         tload;
        logic [TW-1:0] tval;
    } dinit_st_t;
    dinit_st_t s_q, s_d;

    logic        wr_en, rd_en, tdone;
    logic [7:0]  wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic        rd_ok, wr_ok;
    logic [2:0]  seq_ba;
    logic [14:0] seq_a;

    dinit_axil u_axil (
        .clk(clk), .rst_n(rst_n),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_ok(rd_ok), .wr_ok(wr_ok)
    );

    // All waits share one timer; each init wait state loads it on entry
    dinit_timer #(.W(TW)) u_tmr (
        .clk(clk), .rst_n(rst_n),
        .load(s_q.tload), .value(s_q.tval), .done(tdone)
    );

    // Init order MR2, MR3, MR1, MR0
    always_comb begin
        unique case (s_q.idx)
            2'h0: begin
                seq_ba = `DINIT_BA_MR2;
                seq_a  = s_q.mr2;
            end
            2'h1: begin
                seq_ba = `DINIT_BA_MR3;
                seq_a  = s_q.mr3;
            end
            2'h2: begin
                seq_ba = `DINIT_BA_MR1;
                seq_a  = s_q.mr1 & ~(15'h1 << `DINIT_A_DLL_EN_BIT);
            end
            2'h3: begin
                seq_ba = `DINIT_BA_MR0;
                // Reserved A13/A14 forced low, DLL reset requested
                seq_a  = (s_q.mr0 & 15'h1FFF) | (15'h1 << `DINIT_A_DLL_RST_BIT);
            end
        endcase
    end

    always_comb begin
        wr_ok = (wr_addr <= `DINIT_REG_MRS) && (wr_addr[1:0] == 2'h0);
        rd_ok = (rd_addr <= `DINIT_REG_MRS) && (rd_addr[1:0] == 2'h0);
        rd_data = 32'h0;
        unique case (rd_addr)
            `DINIT_REG_CTRL:   rd_data = {29'h0, s_q.odt_hi, s_q.warm, 1'b0};
            `DINIT_REG_STATUS: rd_data = {29'h0, s_q.rt_mrs, !s_q.st[0] && !s_q.done,
                                          s_q.done};
            `DINIT_REG_MR0:    rd_data = {17'h0, s_q.mr0};
            `DINIT_REG_MR1:    rd_data = {17'h0, s_q.mr1};
            `DINIT_REG_MR2:    rd_data = {17'h0, s_q.mr2};
            `DINIT_REG_MR3:    rd_data = {17'h0, s_q.mr3};
            default:           rd_data = 32'h0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.tload   = 1'b0;
        s_d.pin.cmd = DINIT_NOP; // Idle slots carry NOP only
        s_d.pin.ba  = 3'h0;
        s_d.pin.addr = 15'h0;
        if (wr_en) begin
            unique case (wr_addr)
                `DINIT_REG_MR0: s_d.mr0 = wr_data[14:0];
                `DINIT_REG_MR1: s_d.mr1 = wr_data[14:0];
                `DINIT_REG_MR2: s_d.mr2 = wr_data[14:0];
                `DINIT_REG_MR3: s_d.mr3 = wr_data[14:0];
                `DINIT_REG_MRS: begin
                    // Full register value each time
                    s_d.rt_mrs = 1'b1;
                    s_d.rt_ba  = {1'b0, wr_data[17:16]};
                    s_d.rt_a   = wr_data[14:0];
                end
                `DINIT_REG_CTRL: begin
                    s_d.warm   = wr_data[`DINIT_CTRL_WARM];
                    s_d.odt_hi = wr_data[`DINIT_CTRL_ODT_HI];
                    if (wr_data[`DINIT_CTRL_START] && (s_q.st inside {ST_IDLE, ST_READY})) begin
                        s_d.st          = ST_RST;
                        s_d.done        = 1'b0;
                        s_d.pin.reset_n = 1'b0;
                        s_d.pin.cke     = 1'b0;
                        s_d.pin.odt     = 1'b0;
                        s_d.tload       = 1'b1;
                        // Warm reset needs only 100 ns
                        s_d.tval = TW'(wr_data[`DINIT_CTRL_WARM] ? WARM_CYC : T_RST_PWR_CYC);
                    end
                end
                default: ;
            endcase
        end
        unique case (s_q.st)
            ST_IDLE: ;
            ST_RST: begin
                if (tdone) begin
                    s_d.st    = ST_CKELO;
                    s_d.tload = 1'b1;
                    s_d.tval  = TW'(CKE_RST);
                end
            end
            ST_CKELO: begin
                // CKE has been low since reset entry
                if (tdone) begin
                    s_d.pin.reset_n = 1'b1;
                    s_d.st          = ST_RWAIT;
                    s_d.tload       = 1'b1;
                    s_d.tval        = TW'(T_RST_CKE_CYC);
                end
            end
            ST_RWAIT: begin
                if (tdone) begin
                    s_d.ck_en = 1'b1;
                    s_d.st    = ST_CKSTB;
                    s_d.tload = 1'b1;
                    s_d.tval  = TW'(CKSTAB);
                end
            end
            ST_CKSTB: begin
                // NOP already on pins from the cycle before
                if (tdone) begin
                    s_d.pin.cke = 1'b1;
                    s_d.pin.odt = s_q.odt_hi;
                    s_d.st      = ST_XPR;
                    s_d.idx     = 2'h0;
                    s_d.tload   = 1'b1;
                    s_d.tval    = TW'(TXPR_CYC);
                end
            end
            ST_XPR, ST_GAP: begin
                if (tdone) begin
                    s_d.st = ST_MRS;
                end
            end
            ST_MRS: begin
                s_d.pin.cmd  = DINIT_MRS;
                s_d.pin.ba   = seq_ba;
                s_d.pin.addr = seq_a;
                s_d.tload    = 1'b1;
                if (s_q.idx == 2'h3) begin
                    s_d.st   = ST_ZQ;
                    s_d.tval = TW'(TMOD_CYC);
                end else begin
                    s_d.st   = ST_GAP;
                    s_d.idx  = s_q.idx + 2'h1;
                    s_d.tval = TW'(TMRD_CYC);
                end
            end
            ST_ZQ: begin
                if (tdone) begin
                    s_d.pin.cmd  = DINIT_ZQCL;
                    s_d.pin.addr = 15'h1 << `DINIT_A_ZQ_LONG_BIT;
                    s_d.st       = ST_FIN;
                    s_d.tload    = 1'b1;
                    s_d.tval     = TW'(TFIN_CYC);
                end
            end
            ST_FIN: begin
                if (tdone) begin
                    s_d.st   = ST_READY;
                    s_d.done = 1'b1;
                end
            end
            ST_READY: begin
                // Memory idle here; CKE high; one spacing wait covers tMRD and tMOD
                if (s_q.rt_mrs && tdone && !wr_en && s_q.pin.odt) begin
                    // Termination must be off before the load, not with it
                    s_d.pin.odt = 1'b0;
                    s_d.tload   = 1'b1;
                    s_d.tval    = TW'(TMRD_CYC);
                end else if (s_q.rt_mrs && tdone && !wr_en) begin
                    s_d.rt_mrs   = 1'b0;
                    s_d.pin.odt  = 1'b0;
                    s_d.pin.cmd  = DINIT_MRS;
                    s_d.pin.ba   = s_q.rt_ba;
                    s_d.pin.addr = s_q.rt_a;
                    s_d.tload    = 1'b1;
                    s_d.tval     = TW'(TMOD_CYC);
                end else if (tdone && !s_q.tload && !wr_en) begin
                    s_d.pin.odt = s_q.odt_hi;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q          <= '0;
            s_q.st       <= ST_IDLE;
            s_q.pin.cmd  <= DINIT_NOP;
        end else begin
            s_q <= s_d;
        end
    end

    assign mem   = s_q.pin;
    assign ck_en = s_q.ck_en;

    property p_cke_stays;
        @(posedge clk) disable iff (!rst_n)
        (s_q.pin.cke && s_q.st != ST_READY && s_q.st != ST_IDLE && s_q.st != ST_RST)
            |=> s_q.pin.cke;
    endproperty
    a_cke_stays: assert property (p_cke_stays) else $error("CKE dropped in init");

    property p_cke_before_reset;
        @(posedge clk) disable iff (!rst_n)
        $rose(s_q.pin.reset_n) |-> !s_q.pin.cke && $past(!s_q.pin.cke);
    endproperty
    a_cke_before_reset: assert property (p_cke_before_reset)
        else $error("CKE not low before reset release");

    property p_no_cke_soon;
        @(posedge clk) disable iff (!rst_n)
        $rose(s_q.pin.reset_n) |-> !s_q.pin.cke [*8];
    endproperty
    a_no_cke_soon: assert property (p_no_cke_soon) else $error("CKE raised early");

    property p_odt_static;
        @(posedge clk) disable iff (!rst_n)
        (s_q.st inside {ST_XPR, ST_MRS, ST_GAP, ST_ZQ, ST_FIN}) && $past(s_q.pin.cke)
            |-> $stable(s_q.pin.odt);
    endproperty
    a_odt_static: assert property (p_odt_static) else $error("ODT moved in init");

    property p_odt_mrs;
        @(posedge clk) disable iff (!rst_n)
        (s_q.pin.cmd == DINIT_MRS && s_q.st == ST_READY) |-> !s_q.pin.odt && $past(!s_q.pin.odt);
    endproperty
    a_odt_mrs: assert property (p_odt_mrs) else $error("ODT high at MRS");

    property p_mrd;
        @(posedge clk) disable iff (!rst_n)
        (s_q.pin.cmd == DINIT_MRS) |=> (s_q.pin.cmd != DINIT_MRS) [*3];
    endproperty
    a_mrd: assert property (p_mrd) else $error("MRS spacing short");

    property p_mr0_dll;
        @(posedge clk) disable iff (!rst_n)
        (s_q.pin.cmd == DINIT_MRS && s_q.st == ST_ZQ)
            |-> s_q.pin.ba == `DINIT_BA_MR0 && s_q.pin.addr[8] && s_q.pin.addr[14:13] == 2'h0;
    endproperty
    a_mr0_dll: assert property (p_mr0_dll) else $error("MR0 load malformed");

    property p_mr1_dll;
        @(posedge clk) disable iff (!rst_n)
        (s_q.pin.cmd == DINIT_MRS && s_q.pin.ba == `DINIT_BA_MR1 && s_q.st != ST_READY)
            |-> !s_q.pin.addr[0];
    endproperty
    a_mr1_dll: assert property (p_mr1_dll) else $error("MR1 DLL not enabled");

    property p_mod;
        @(posedge clk) disable iff (!rst_n)
        (s_q.pin.cmd == DINIT_MRS) |=> (s_q.pin.cmd != DINIT_ZQCL) [*8];
    endproperty
    a_mod: assert property (p_mod) else $error("command inside tMOD");

    c_init_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_q.done));
    c_warm:      cover property (@(posedge clk) disable iff (!rst_n) s_q.warm && $rose(s_q.done));
    c_rt_mrs:    cover property (@(posedge clk) disable iff (!rst_n)
                     s_q.st == ST_READY && s_q.pin.cmd == DINIT_MRS);
endmodule

// >>> testbench/dinit_mem.sv
// Behavioural DDR3 memory that logs mode loads and init timing
module dinit_mem
    import dinit_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        ck_en,
    input  wire dinit_pins_t mem,
    output logic [14:0]      mr [4],
    output int               lo_cyc,
    output int               hi_cyc,
    output int               ck_cyc,
    output int               xpr,
    output int               gap_min,
    output logic [11:0]      order,
    output logic             zq_ok,
    output logic             rtt_on
);
    timeunit 1ns;
    timeprecision 1ns;
    int   gap;
    logic rn_q = 1'b1;
    logic dll_rst;
    always_ff @(posedge clk) begin
        rn_q <= mem.reset_n;
        dll_rst <= 1'b0; // Self-clearing
        if (!mem.reset_n) begin
            lo_cyc <= rn_q ? 1 : lo_cyc + 1;
            {hi_cyc, gap, ck_cyc, order, zq_ok} <= '0;
            gap_min <= 999;
            rtt_on <= 1'b0;
        end else if (!mem.cke) begin
            hi_cyc <= hi_cyc + 1;
            ck_cyc <= ck_en ? ck_cyc + 1 : 0;
        end else begin
            rtt_on <= 1'b1; // Only once CKE seen high
            gap <= gap + 1;
            if (mem.cmd == DINIT_MRS) begin // No array state touched
                mr[mem.ba[1:0]] <= mem.addr;
                order <= {order[8:0], mem.ba};
                if (order == '0) xpr <= gap;
                else if (gap < gap_min) gap_min <= gap;
                gap <= 1;
                dll_rst <= mem.ba == 3'h0 && mem.addr[8];
            end
            if (mem.cmd == DINIT_ZQCL) zq_ok <= gap >= 12 && order[2:0] == 3'h0;
        end
    end
endmodule

// >>> testbench/testbench.sv
// Register-level bench for the DDR3 init controller
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dinit_pkg::*;
    logic        clk, rst_n, ck_en, zq_ok, rtt_on;
    logic [7:0]  s_awaddr, s_araddr;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata, d;
    logic [1:0]  s_bresp, s_rresp, r;
    logic [11:0] order;
    logic [14:0] mr [4];
    dinit_pins_t mem;
    int          lo_cyc, hi_cyc, ck_cyc, xpr, gap_min;
    int          bad_count = 0;
    int          n_compared = 0;

    dinit_ctrl #(.T_RST_PWR_CYC(50), .T_RST_CKE_CYC(50), .TDLLK_CYC(20),
        .TZQINIT_CYC(20)) u_dut (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .ck_en, .mem);
    dinit_mem u_mem (.clk, .ck_en, .mem, .mr, .lo_cyc, .hi_cyc, .ck_cyc, .xpr,
        .gap_min, .order, .zq_ok, .rtt_on);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Bresp expectation: anything past the last register is refused
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit ap, wp;
        ap = 1;
        wp = 1;
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (ap || wp) begin
            @(posedge clk);
            if (ap && s_awready) begin
                ap = 0;
                s_awvalid <= 1'b0;
            end
            if (wp && s_wready) begin
                wp = 0;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_bvalid);
        chk("bresp", s_bresp, a > 8'h18 ? 2'h2 : 2'h0);
    endtask

    task automatic rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge clk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge clk); while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
    endtask

    task automatic start(input logic [31:0] v);
        int i;
        wr(8'h00, v);
        rd(8'h04);
        chk("busy", d[1], 1'b1);
        for (i = 0; i < 300 && d[0] !== 1'b1; i++) rd(8'h04);
        chk("done", d, 32'h1);
        chk("order", order, 12'h4C8);
        chk("zqcl", zq_ok, 1'b1);
        chk("cke", mem.cke, 1'b1);
        chk("odt", mem.odt, 1'b0);
        chk("rtt", rtt_on, 1'b1);
        chk("txpr", xpr >= 17, 1'b1);
        chk("tmrd", gap_min >= 4, 1'b1);
        chk("ck", ck_cyc >= 5, 1'b1);
        chk("cke wait", hi_cyc >= 50, 1'b1);
    endtask

    initial begin
        {rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h04);
        chk("idle", d, 32'h0);
        rd(8'h1C);
        chk("rresp", r, 2'h2);
        wr(8'h20, 32'h1);
        wr(8'h08, 32'h6000);
        wr(8'h0C, 32'h0045);
        wr(8'h10, 32'h0018);
        wr(8'h14, 32'h0004);
        start(32'h1);
        chk("reset low", lo_cyc >= 50, 1'b1);
        chk("mr0", mr[0], 15'h0100);
        chk("mr1", mr[1], 15'h0044);
        chk("mr2", mr[2], 15'h0018);
        chk("mr3", mr[3], 15'h0004);
        wr(8'h00, 32'h4);
        repeat (4) @(posedge clk);
        chk("odt hi", mem.odt, 1'b1);
        wr(8'h18, 32'h0002_0123);
        // Termination drops first, and returns only after tMOD
        repeat (40) @(posedge clk);
        chk("mr2 run", mr[2], 15'h0123);
        chk("odt back", mem.odt, 1'b1);
        start(32'h3);
        chk("warm", lo_cyc >= 10 && lo_cyc < 50, 1'b1);
        summarize;
    end

    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        summarize;
    end
endmodule
